// >>> hw/tbwdg_regs.svh
// Register indices, field positions, reset values and counts of the timebase watchdog timer
`ifndef TBWDG_REGS_SVH
`define TBWDG_REGS_SVH

// Register indices; the byte address is four times the index
`define TBWDG_IDX_CSR 8'h0B
`define TBWDG_IDX_CAPTURE 8'h0C
`define TBWDG_IDX_OPTION 8'h0D

// Control/status fields
`define TBWDG_CSR_WDOG_DELAY 0
`define TBWDG_CSR_WDOG_EN 1
`define TBWDG_CSR_FORCE_STATUS 2
`define TBWDG_CSR_TBASE_FLAG 3
`define TBWDG_CSR_TBASE_IRQ_EN 4
`define TBWDG_CSR_TBASE_SEL 5
`define TBWDG_CSR_CAP_FLAG 6
`define TBWDG_CSR_CAP_IRQ_EN 7

// Option fields
`define TBWDG_OPT_HW_WDOG 0
`define TBWDG_OPT_RESET_ON_HALT 1
`define TBWDG_OPT_LONG_WAKE 2
`define TBWDG_OPT_RESET 3'h0

// Counter and timing counts
`define TBWDG_CNT_TERMINAL 13'h1F39
`define TBWDG_WAKE_SHORT 10'h100
`define TBWDG_WAKE_LONG 10'h200

`endif

// >>> hw/tbwdg_pkg.sv
// Types shared by the timebase watchdog timer modules
package tbwdg_pkg;
	typedef logic [7:0] tbwdg_adr_t;
	typedef logic [31:0] tbwdg_data_t;
	typedef logic [3:0] tbwdg_sel_t;
	typedef logic [12:0] tbwdg_count_t;

	typedef enum logic [1:0] {
		TBWDG_RUN = 2'h0,
		TBWDG_HALTED = 2'h1,
		TBWDG_WAKING = 2'h3
	} tbwdg_pwr_t;
endpackage : tbwdg_pkg

// >>> hw/tbwdg_cnt_if.sv
// Link between the watchdog control logic and the hidden free-running counter
`timescale 1ns/1ps
interface tbwdg_cnt_if;
	logic run;
	logic wrap;
	logic [7:0] msb;

	modport control (output run, input wrap, input msb);
	modport counter (input run, output wrap, output msb);
endinterface : tbwdg_cnt_if

// >>> hw/tbwdg_counter.sv
// Hidden 13-bit free-running upcounter with overflow event
`timescale 1ns/1ps
`include "tbwdg_regs.svh"
module tbwdg_counter #(
	parameter logic [12:0] TERMINAL = `TBWDG_CNT_TERMINAL
) (
	input wire logic clock,
	input wire logic reset,
	tbwdg_cnt_if.counter cnt
);
	import tbwdg_pkg::*;

	tbwdg_count_t count_ff;

	always_ff @(posedge clock) begin
		if (reset) begin
			count_ff <= 13'h0000;
		end else if (cnt.run) begin
			if (count_ff == TERMINAL) begin
				count_ff <= 13'h0000;
			end else begin
				count_ff <= count_ff + 13'h0001;
			end
		end
	end

	assign cnt.wrap = cnt.run && (count_ff == TERMINAL);
	assign cnt.msb = count_ff[12:5];
endmodule : tbwdg_counter

// >>> hw/tbwdg_top.sv
// Timebase, input capture and watchdog timer with a classic Wishbone register slave
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tbwdg_regs.svh"
module tbwdg_top #(
	parameter logic [2:0] OPTION_RESET = `TBWDG_OPT_RESET
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic LOW_VOLTAGE_RESET,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire tbwdg_pkg::tbwdg_adr_t ADR_I,
	input wire tbwdg_pkg::tbwdg_data_t DAT_I,
	input wire tbwdg_pkg::tbwdg_sel_t SEL_I,
	output tbwdg_pkg::tbwdg_data_t DAT_O,
	output logic ACK_O,
	input wire logic HALT_ENTER,
	input wire logic EXT_WAKE,
	input wire logic CAPTURE_INPUT_PIN,
	output logic TIMEBASE_IRQ,
	output logic CAPTURE_IRQ,
	output logic WATCHDOG_RESET_REQ
);
	import tbwdg_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	tbwdg_cnt_if cnt ();

	logic ack_ff;
	tbwdg_data_t dat_ff;
	logic access;
	logic wr_csr;
	logic wr_opt;
	logic rd_csr;
	logic rd_cap;
	logic [7:0] wdata;

	logic watchdog_delay_refresh_ff;
	logic watchdog_enable_ff;
	logic status_ff;
	logic tflag_ff;
	logic timebase_irq_enable_ff;
	logic tsel_ff;
	logic icf_ff;
	logic capture_irq_enable_ff;
	logic [7:0] capture_ff;
	logic [2:0] option_ff;

	logic half_ff;
	logic late_ff;
	logic active_q_ff;
	logic cap_pin_q_ff;
	logic req_ff;
	tbwdg_pwr_t pwr_ff;
	logic [9:0] wake_ff;

	logic active;
	logic period_end;
	logic tbase_event;
	logic capture_edge;
	logic enable_rise;
	logic trigger;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic hit(input tbwdg_adr_t adr, input logic [7:0] idx);
		hit = (adr[7:2] == idx[5:0]) && (adr[1:0] == 2'h0);
	endfunction : hit

	// ------------------------------------------------------------
	// Hidden counter
	// ------------------------------------------------------------
	tbwdg_counter u_counter (
		.clock(CLOCK),
		.reset(RESET),
		.cnt(cnt.counter)
	);

	// Stopped with the oscillator in halt and during the wake delay
	assign cnt.run = (pwr_ff == TBWDG_RUN);

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	// Answer one cycle after the request; effects land on the acknowledged edge
	assign access = CYC_I && STB_I && ack_ff;
	assign wdata = DAT_I[7:0];
	assign wr_csr = access && WE_I && SEL_I[0] && hit(ADR_I, `TBWDG_IDX_CSR);
	assign wr_opt = access && WE_I && SEL_I[0] && hit(ADR_I, `TBWDG_IDX_OPTION);
	assign rd_csr = access && !WE_I && hit(ADR_I, `TBWDG_IDX_CSR);
	assign rd_cap = access && !WE_I && hit(ADR_I, `TBWDG_IDX_CAPTURE);

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= CYC_I && STB_I && !ack_ff;
		end
	end

	// Read data is sampled in the request cycle; the timebase and status flag clears use these
	// sampled bits so a flag set in between is never lost, while a capture read clears its flag outright
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			dat_ff <= 32'h00000000;
		end else if (CYC_I && STB_I && !ack_ff) begin
			dat_ff <= 32'h00000000;
			if (hit(ADR_I, `TBWDG_IDX_CSR)) begin
				dat_ff[7:0] <= {capture_irq_enable_ff, icf_ff, tsel_ff, timebase_irq_enable_ff, tflag_ff, status_ff, watchdog_enable_ff, watchdog_delay_refresh_ff};
			end else if (hit(ADR_I, `TBWDG_IDX_CAPTURE)) begin
				dat_ff[7:0] <= capture_ff;
			end else if (hit(ADR_I, `TBWDG_IDX_OPTION)) begin
				dat_ff[2:0] <= option_ff;
			end
		end
	end

	assign ACK_O = ack_ff;
	assign DAT_O = dat_ff;

	// ------------------------------------------------------------
	// Software control bits
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			timebase_irq_enable_ff <= 1'b0;
			tsel_ff <= 1'b0;
			capture_irq_enable_ff <= 1'b0;
		end else if (wr_csr) begin
			timebase_irq_enable_ff <= wdata[`TBWDG_CSR_TBASE_IRQ_EN];
			tsel_ff <= wdata[`TBWDG_CSR_TBASE_SEL];
			capture_irq_enable_ff <= wdata[`TBWDG_CSR_CAP_IRQ_EN];
		end
	end

	// Option bits stand in for the option byte; reset restores the defaults
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			option_ff <= OPTION_RESET;
		end else if (wr_opt) begin
			option_ff <= wdata[2:0];
		end
	end

	// ------------------------------------------------------------
	// Timebase
	// ------------------------------------------------------------
	// Every second wrap closes a 15988 clock span
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			half_ff <= 1'b0;
		end else if (cnt.wrap) begin
			half_ff <= !half_ff;
		end
	end

	assign tbase_event = cnt.wrap && (!tsel_ff || half_ff);
	assign period_end = cnt.wrap && half_ff;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			tflag_ff <= 1'b0;
		end else if (tbase_event) begin
			tflag_ff <= 1'b1;
		end else if (rd_csr && dat_ff[`TBWDG_CSR_TBASE_FLAG]) begin
			tflag_ff <= 1'b0;
		end
	end

	assign TIMEBASE_IRQ = tflag_ff && timebase_irq_enable_ff;

	// ------------------------------------------------------------
	// Input capture
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			cap_pin_q_ff <= CAPTURE_INPUT_PIN; // Follows the pin so no false edge appears at release
		end else begin
			cap_pin_q_ff <= CAPTURE_INPUT_PIN;
		end
	end

	assign capture_edge = (CAPTURE_INPUT_PIN != cap_pin_q_ff) && !icf_ff;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			capture_ff <= 8'h00;
		end else if (capture_edge) begin
			capture_ff <= cnt.msb;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			icf_ff <= 1'b0;
		end else if (capture_edge) begin
			icf_ff <= 1'b1;
		end else if (rd_cap) begin
			icf_ff <= 1'b0;
		end
	end

	assign CAPTURE_IRQ = icf_ff && capture_irq_enable_ff;

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	assign active = option_ff[`TBWDG_OPT_HW_WDOG] || watchdog_enable_ff;
	assign enable_rise = active && !active_q_ff;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			watchdog_enable_ff <= 1'b0;
		end else if (wr_csr) begin
			watchdog_enable_ff <= wdata[`TBWDG_CSR_WDOG_EN];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			active_q_ff <= 1'b0;
		end else begin
			active_q_ff <= active;
		end
	end

	// A refresh written on the period edge wins over the hardware clear
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			watchdog_delay_refresh_ff <= 1'b0;
		end else if (wr_csr && wdata[`TBWDG_CSR_WDOG_DELAY]) begin
			watchdog_delay_refresh_ff <= 1'b1;
		end else if (period_end) begin
			watchdog_delay_refresh_ff <= 1'b0;
		end
	end

	// Remembers an unrefreshed period that passed while disabled
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			late_ff <= 1'b0;
		end else if (period_end && !active && !watchdog_delay_refresh_ff) begin
			late_ff <= 1'b1;
		end
	end

	// Survives the watchdog reset it reports; of the resets only a low-voltage reset clears it
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			if (LOW_VOLTAGE_RESET) begin
				status_ff <= 1'b0;
			end
		end else if (req_ff) begin
			status_ff <= 1'b1;
		end else if (wr_csr && wdata[`TBWDG_CSR_FORCE_STATUS]) begin
			status_ff <= 1'b1;
		end else if (rd_csr && dat_ff[`TBWDG_CSR_FORCE_STATUS]) begin
			status_ff <= 1'b0;
		end else if (wr_csr) begin
			status_ff <= 1'b0;
		end
	end

	always_comb begin
		trigger = 1'b0;
		if (pwr_ff == TBWDG_RUN) begin
			if (active && period_end && !watchdog_delay_refresh_ff) begin
				trigger = 1'b1;
			end
			if (enable_rise && late_ff && !watchdog_delay_refresh_ff) begin
				trigger = 1'b1;
			end
			if (enable_rise && status_ff) begin
				trigger = 1'b1;
			end
			if (wr_csr && wdata[`TBWDG_CSR_FORCE_STATUS] && active) begin
				trigger = 1'b1;
			end
			if (HALT_ENTER && active && option_ff[`TBWDG_OPT_RESET_ON_HALT]) begin
				trigger = 1'b1;
			end
		end
	end

	// One pulse only; the reset controller answers by asserting RESET
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			req_ff <= 1'b0;
		end else begin
			req_ff <= trigger && !req_ff;
		end
	end

	assign WATCHDOG_RESET_REQ = req_ff;

	// ------------------------------------------------------------
	// Halt handling
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			pwr_ff <= TBWDG_RUN;
		end else begin
			unique case (pwr_ff)
				TBWDG_RUN: begin
					if (HALT_ENTER && !(active && option_ff[`TBWDG_OPT_RESET_ON_HALT])) begin
						pwr_ff <= TBWDG_HALTED;
					end
				end
				TBWDG_HALTED: begin
					if (EXT_WAKE) begin
						pwr_ff <= TBWDG_WAKING;
					end
				end
				TBWDG_WAKING: begin
					if (wake_ff == 10'h001) begin
						pwr_ff <= TBWDG_RUN;
					end
				end
				default: begin
					pwr_ff <= TBWDG_RUN;
				end
			endcase
		end
	end

	// Wake delay counter loads on the external wake
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			wake_ff <= 10'h000;
		end else if (pwr_ff == TBWDG_HALTED && EXT_WAKE) begin
			wake_ff <= option_ff[`TBWDG_OPT_LONG_WAKE] ? `TBWDG_WAKE_LONG : `TBWDG_WAKE_SHORT;
		end else if (wake_ff != 10'h000) begin
			wake_ff <= wake_ff - 10'h001;
		end
	end
endmodule : tbwdg_top

// >>> tb/tbwdg_rst_model.sv
// Reset controller model that answers watchdog reset requests
`timescale 1ns/1ps
module tbwdg_rst_model (
	input wire logic clock,
	input wire logic por,
	input wire logic req,
	output logic rst
);
	logic [2:0] hold_ff;

	// Power-on reset clears the hold count; a request pulse starts a short reset
	always_ff @(posedge clock) begin
		if (por) begin
			hold_ff <= 3'h0;
		end else if (req) begin
			hold_ff <= 3'h4;
		end else if (hold_ff != 3'h0) begin
			hold_ff <= hold_ff - 3'h1;
		end
	end

	assign rst = por | (hold_ff != 3'h0);
endmodule : tbwdg_rst_model

// >>> tb/tbwdg_monitor.sv
// Port checker of the timebase watchdog timer
`timescale 1ns/1ps
module tbwdg_monitor #(
	parameter logic [2:0] OPTION_RESET = 3'h0
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire tbwdg_pkg::tbwdg_adr_t ADR_I,
	input wire tbwdg_pkg::tbwdg_data_t DAT_I,
	input wire tbwdg_pkg::tbwdg_sel_t SEL_I,
	input wire tbwdg_pkg::tbwdg_data_t DAT_O,
	input wire logic ACK_O,
	input wire logic HALT_ENTER,
	input wire logic TIMEBASE_IRQ,
	input wire logic CAPTURE_IRQ,
	input wire logic WATCHDOG_RESET_REQ
);
	import tbwdg_pkg::*;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	// Tracks the reset-on-halt option bit as software writes it
	logic halt_rst_ff;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			halt_rst_ff <= OPTION_RESET[1];
		end else if (CYC_I && STB_I && WE_I && ACK_O && SEL_I[0] && ADR_I == 8'h34) begin
			halt_rst_ff <= DAT_I[1];
		end
	end

	a_ack_latency: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("late ack");
	a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("long ack");
	a_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h0) else $error("upper read bits set");
	a_unmapped_zero: assert property (ACK_O && !WE_I && !(ADR_I inside {8'h2C, 8'h30, 8'h34})
		|-> DAT_O == 32'h0) else $error("unmapped read not zero");
	a_req_single: assert property (WATCHDOG_RESET_REQ |=> !WATCHDOG_RESET_REQ) else $error("long request");
	// Only valid without the reset-on-halt option, hence the tracked option bit in the antecedent
	a_halt_quiet: assert property (HALT_ENTER && !halt_rst_ff |=> !WATCHDOG_RESET_REQ [*8])
		else $error("request while halted");
	a_tb_irq_clear: assert property ($fell(TIMEBASE_IRQ) |-> $past(ACK_O) && $past(ADR_I) == 8'h2C)
		else $error("timebase irq dropped alone");
	a_cap_irq_clear: assert property ($fell(CAPTURE_IRQ) |-> $past(ACK_O) &&
		($past(ADR_I) == 8'h30 || $past(ADR_I) == 8'h2C && $past(WE_I))) else $error("capture irq dropped alone");

	c_wdog_reset: cover property (WATCHDOG_RESET_REQ);
	c_tb_irq: cover property ($rose(TIMEBASE_IRQ));
	c_halt: cover property (HALT_ENTER);
endmodule : tbwdg_monitor

bind tbwdg_top tbwdg_monitor #(.OPTION_RESET(OPTION_RESET)) u_mon (.CLOCK(CLOCK), .RESET(RESET), .CYC_I(CYC_I),
	.STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .HALT_ENTER(HALT_ENTER),
	.DAT_I(DAT_I), .SEL_I(SEL_I),
	.TIMEBASE_IRQ(TIMEBASE_IRQ), .CAPTURE_IRQ(CAPTURE_IRQ), .WATCHDOG_RESET_REQ(WATCHDOG_RESET_REQ));

// >>> tb/tb.sv
// Self-checking testbench of the timebase watchdog timer
`timescale 1ns/1ps
`include "tbwdg_regs.svh"
module tb;
	import tbwdg_pkg::*;
	// One overflow span: the count runs from zero up to the terminal value
	localparam int PERIOD = `TBWDG_CNT_TERMINAL + 1;
	logic CLOCK = 1'h0, por = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, halt = 1'h0, wake = 1'h0, pin = 1'h0;
	tbwdg_adr_t adr = 8'h00;
	tbwdg_data_t wd = 32'h0, dat_o;
	logic ack, tb_irq, cap_irq, req, rst;
	logic [7:0] rd;
	int n_errors = 0, check_count = 0, cnt = 0, n_req = 0, exp_req = 0, k, n;

	initial forever #12.5 CLOCK = ~CLOCK;
	// Cycle count since reset release, and a sticky count of request pulses
	always @(posedge CLOCK) cnt <= rst ? 0 : cnt + 1;
	always @(posedge CLOCK) if (req === 1'h1) n_req <= n_req + 1;

	tbwdg_rst_model u_rst (.clock(CLOCK), .por(por), .req(req), .rst(rst));
	tbwdg_top u_dut (.CLOCK(CLOCK), .RESET(rst), .LOW_VOLTAGE_RESET(por), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .DAT_I(wd), .SEL_I(4'hF), .DAT_O(dat_o), .ACK_O(ack), .HALT_ENTER(halt), .EXT_WAKE(wake),
		.CAPTURE_INPUT_PIN(pin), .TIMEBASE_IRQ(tb_irq), .CAPTURE_IRQ(cap_irq), .WATCHDOG_RESET_REQ(req));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_sim();
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [7:0] near(input int a, input int b);
		return {7'h0, a >= b - 6 && a <= b + 6};
	endfunction : near

	// Classic single cycle; the answer is awaited, never assumed
	task automatic bus(input logic w, input tbwdg_adr_t a, input logic [7:0] d);
		int i;
		i = 0;
		@(posedge CLOCK);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wd <= {24'h0, d};
		do begin
			@(posedge CLOCK);
			i++;
		end while (ack !== 1'h1 && i < 50);
		if (i >= 50) begin
			n_errors++;
			end_sim();
		end
		rd = dat_o[7:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge CLOCK);
	endtask : bus

	task automatic rdc(input tbwdg_adr_t a, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		chk(rd, e);
	endtask : rdc

	task automatic wait_sig(input logic sel, input int lim, input logic must, output int m);
		m = 0;
		do begin
			@(posedge CLOCK);
			m++;
		end while ((sel ? tb_irq !== 1'h1 : n_req < exp_req) && m < lim);
		if (must && m >= lim) begin
			n_errors++;
			end_sim();
		end
	endtask : wait_sig

	task automatic pulse(input logic h);
		@(posedge CLOCK);
		halt <= h;
		wake <= !h;
		@(posedge CLOCK);
		halt <= 1'h0;
		wake <= 1'h0;
	endtask : pulse

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge CLOCK);
		por <= 1'h0;
		rdc(8'h2C, 8'h00);
		rdc(8'h30, 8'h00);
		rdc(8'h34, 8'h00);
		bus(1'h1, 8'h3C, 8'hFF);
		rdc(8'h3C, 8'h00);
		bus(1'h1, 8'h2C, 8'h80);
		k = cnt;
		pin <= 1'h1;
		repeat (3) @(posedge CLOCK);
		chk({7'h0, cap_irq}, 8'h01);
		// The counter stands at k + 1 at the edge that sees the pin change
		rdc(8'h30, 8'((k + 1) >> 5));
		chk({7'h0, cap_irq}, 8'h00);
		bus(1'h1, 8'h2C, 8'h10);
		wait_sig(1'h1, 9000, 1'h1, n);
		chk(near(cnt, PERIOD), 8'h01);
		rdc(8'h2C, 8'h18);
		rdc(8'h2C, 8'h10);
		chk({7'h0, tb_irq}, 8'h00);
		bus(1'h1, 8'h2C, 8'h30);
		wait_sig(1'h1, 17000, 1'h1, n);
		k = cnt;
		rdc(8'h2C, 8'h38);
		wait_sig(1'h1, 17000, 1'h1, n);
		chk(near(cnt - k, 2 * PERIOD), 8'h01);
		// Periods have ended unrefreshed, so a late enable must reset at once
		exp_req++;
		bus(1'h1, 8'h2C, 8'h02);
		wait_sig(1'h0, 10, 1'h1, n);
		repeat (8) @(posedge CLOCK);
		rdc(8'h2C, 8'h04);
		rdc(8'h2C, 8'h00);
		exp_req++;
		bus(1'h1, 8'h2C, 8'h03);
		wait_sig(1'h0, 40000, 1'h1, n);
		chk(near(cnt, 4 * PERIOD), 8'h01);
		repeat (8) @(posedge CLOCK);
		rdc(8'h2C, 8'h04);
		exp_req++;
		bus(1'h1, 8'h2C, 8'h02);
		bus(1'h1, 8'h2C, 8'h06);
		wait_sig(1'h0, 10, 1'h1, n);
		repeat (8) @(posedge CLOCK);
		rdc(8'h2C, 8'h04);
		// No refresh before halt, so the request follows the wake delay
		bus(1'h1, 8'h2C, 8'h02);
		k = cnt + 2;
		pulse(1'h1);
		exp_req++;
		wait_sig(1'h0, 17000, 1'h0, n);
		chk({7'h0, n == 17000}, 8'h01);
		pulse(1'h0);
		wait_sig(1'h0, 17000, 1'h1, n);
		chk(near(n, 2 * PERIOD + `TBWDG_WAKE_SHORT - k), 8'h01);
		// Status still set when the hardware option turns the watchdog on
		repeat (8) @(posedge CLOCK);
		exp_req++;
		bus(1'h1, 8'h34, 8'h01);
		wait_sig(1'h0, 10, 1'h1, n);
		repeat (8) @(posedge CLOCK);
		rdc(8'h2C, 8'h04);
		bus(1'h1, 8'h2C, 8'h01);
		bus(1'h1, 8'h34, 8'h03);
		exp_req++;
		pulse(1'h1);
		wait_sig(1'h0, 10, 1'h1, n);
		end_sim();
	end
endmodule : tb
